// file: hdl/dma_defines.vh
`ifndef DMA_DEFINES_VH
`define DMA_DEFINES_VH

// ----------------------------------------
// commands
// ----------------------------------------
`define CMD_ENABLE 8'h87
`define CMD_DISABLE 8'h83
`define CMD_LOAD 8'hcf
`define CMD_RESET 8'hc3
`define CMD_INIT_READ 8'ha7
`define CMD_READ_STATUS 8'hbf
`define CMD_READ_MASK 8'hbb

// ----------------------------------------
// base byte fields
// ----------------------------------------
`define BASE_HI 7
`define GROUP_LO 1:0
`define DIR_BIT 2
`define TB_IO 3
`define TB_INCR 4
`define TB_FIXED 5
`define TB_FOLLOW 6
`define MODE_FIELD 6:5
`define RW_RDY_HIGH 3
`define RW_WAIT 4
`define RW_RESTART 5
`define TV_LEN 1:0
`define TV_IO_REQUEST_STROBE_EARLY 2
`define TV_MEMORY_REQUEST_STROBE_EARLY 3
`define TV_RD_EARLY 4
`define TV_WR_EARLY 5
`define IC_PULSE 3
`define IC_VECTOR 4
`define MODE_BYTE 2'h0
`define MODE_CONT 2'h1
`define MODE_BURST 2'h2
`define XFER_PTRS 6:3
`define MB_B_LO 2
`define MB_B_HI 3
`define MB_INTCTL 4
`define CB_MASK 3
`define CB_MATCH 4
`define RMASK_FIELD 6:0

// ----------------------------------------
// pending pointer slots, in group order
// ----------------------------------------
`define PEND_W 14
`define P_A_LO 0
`define P_A_HI 1
`define P_LEN_LO 2
`define P_LEN_HI 3
`define P_TIM_A 4
`define P_TIM_B 5
`define P_MASK 6
`define P_MATCH 7
`define P_B_LO 8
`define P_B_HI 9
`define P_INTCTL 10
`define P_PULSE 11
`define P_VECTOR 12
`define P_RMASK 13

// ----------------------------------------
// read sequence, status and reset values
// ----------------------------------------
`define RR_LAST 3'h6
`define ST_XFER 0
`define ST_READY 1
`define ST_NOT_END 5
`define RST_READ_MASK 7'h7f
`define ZERO8 8'h00
`define ZERO16 16'h0000
`define PEND_NONE 14'h0000

// ----------------------------------------
// cycle timing, one period is two clocks
// ----------------------------------------
`define CYC_2 3'h2
`define CYC_3 3'h3
`define CYC_4 3'h4
`define WAIT_AT_MEM 3'h2
`define WAIT_AT_IO 3'h3
`define T_IDLE 3'h0
`define T_FIRST 3'h1
`endif

// file: hdl/dma_byte_fifo.v
`timescale 1ns/1ps
module dma_byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // fill side
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  // drain side
  output reg out_valid,
  output reg [WIDTH-1:0] out_data,
  input wire out_ready
);
  localparam [AW:0] FULL = DEPTH[AW:0];
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr;
  reg [AW-1:0] rptr;
  reg [AW:0] count;
  wire push;
  wire load;

  // ----------------------------------------
  // flow control
  // ----------------------------------------
  assign in_ready = count != FULL;
  assign push = in_valid && in_ready;
  // output register refills when empty or being drained
  assign load = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);

  // memory has no reset, it holds data only
  always @(posedge clk_sys) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  // pointers wrap naturally since depth is a power of two
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (load) begin
        rptr <= rptr + 1'b1;
        out_data <= mem[rptr];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      if (push && !load) begin
        count <= count + 1'b1;
      end else if (load && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// file: hdl/single_channel_dma_controller.v
`timescale 1ns/1ps
`include "dma_defines.vh"
module single_channel_dma_controller (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // shared data bus
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg data_oe_b,
  // host select and strobes
  input wire chip_enable_wait_b,
  input wire io_request_strobe_in_b,
  input wire read_strobe_in_b,
  input wire write_strobe_in_b,
  // bus master address and strobes
  output reg [15:0] addr_out,
  output reg addr_oe_b,
  output reg io_request_strobe_out_b,
  output reg memory_request_strobe_b,
  output reg read_strobe_out_b,
  output reg write_strobe_out_b,
  output reg ctrl_oe_b,
  // bus arbitration
  input wire bus_request_line_in_b,
  output reg bus_request_line_out,
  output reg bus_request_line_oe_b,
  input wire bus_grant_in_b,
  input wire ready_in
);
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_REQ = 6'h02;
  localparam [5:0] S_GRANT = 6'h04;
  localparam [5:0] S_READ = 6'h08;
  localparam [5:0] S_WRITE = 6'h10;
  localparam [5:0] S_DROP = 6'h20;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [3:0] first_pend;
    input [`PEND_W-1:0] p;
    integer i;
    begin
      first_pend = 4'h0;
      for (i = `PEND_W - 1; i >= 0; i = i - 1) begin
        if (p[i]) begin
          first_pend = i[3:0];
        end
      end
    end
  endfunction

  function [2:0] next_unmasked;
    input [6:0] m;
    input [2:0] p;
    integer j;
    integer k;
    begin
      next_unmasked = p;
      for (j = 7; j >= 1; j = j - 1) begin
        k = (p + j) % 7;
        if (m[k]) begin
          next_unmasked = k[2:0];
        end
      end
    end
  endfunction

  function [2:0] cyc_len;
    input var_mode;
    input [1:0] code;
    input io;
    begin
      if (!var_mode) begin
        cyc_len = io ? `CYC_4 : `CYC_3;
      end else begin
        case (code)
          2'h1: cyc_len = `CYC_3;
          2'h2: cyc_len = `CYC_2;
          default: cyc_len = `CYC_4;
        endcase
      end
    end
  endfunction

  function [15:0] step_addr;
    input [15:0] a;
    input [7:0] tb;
    begin
      if (tb[`TB_FIXED]) begin
        step_addr = a;
      end else if (tb[`TB_INCR]) begin
        step_addr = a + 16'h0001;
      end else begin
        step_addr = a - 16'h0001;
      end
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg enabled;
  reg [1:0] op;
  reg dir_a2b;
  reg [15:0] start_a;
  reg [15:0] start_b;
  reg [15:0] block_len;
  reg [15:0] cnt_a;
  reg [15:0] cnt_b;
  reg [15:0] byte_cnt;
  reg [7:0] timing_a_base;
  reg [7:0] timing_b_base;
  reg [7:0] timing_a_var;
  reg [7:0] timing_b_var;
  reg var_a;
  reg var_b;
  reg [1:0] mode;
  reg rdy_high;
  reg wait_en;
  reg auto_restart;
  reg [6:0] read_mask;
  reg [2:0] read_ptr;
  reg [`PEND_W-1:0] pend;
  reg xfer_seen;
  reg block_end;
  reg [5:0] state;
  reg [5:0] next_state;
  reg [2:0] tcnt;
  reg [2:0] next_tcnt;
  reg ph;
  reg next_ph;
  reg [7:0] rd_byte;
  reg hold_data;
  reg host_wr_q;
  reg host_rd_q;
  reg [7:0] rr_val;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire [3:0] slot;

  // ----------------------------------------
  // current port and cycle shape
  // ----------------------------------------
  wire owner = (state == S_READ) || (state == S_WRITE);
  wire cur_a = (state == S_READ) ? dir_a2b : !dir_a2b;
  wire [7:0] cur_tb = cur_a ? timing_a_base : timing_b_base;
  wire [7:0] cur_tv = cur_a ? timing_a_var : timing_b_var;
  wire cur_var = cur_a ? var_a : var_b;
  wire cur_io = cur_tb[`TB_IO];
  wire [2:0] cur_len = cyc_len(cur_var, cur_tv[`TV_LEN], cur_io);
  wire [2:0] wait_idx = cur_io ? `WAIT_AT_IO : `WAIT_AT_MEM;
  // variable cycles only stretch the longer lengths
  wire wait_ok = wait_en && (!cur_var || (cur_io ? cur_len == `CYC_4 : cur_len != `CYC_2));
  wire ready_act = rdy_high ? ready_in : !ready_in;
  wire hold_wait = wait_ok && tcnt == wait_idx && !chip_enable_wait_b;
  wire at_last = tcnt == cur_len;
  wire cyc_end = owner && tcnt != `T_IDLE && at_last && ph && !hold_wait;
  wire rd_done = (state == S_READ) && cyc_end;
  wire wr_done = (state == S_WRITE) && cyc_end;
  wire cyc_start_rd = (state == S_READ) && tcnt == `T_IDLE && ready_act && fifo_in_ready
    && op[0];
  wire cyc_start_wr = (state == S_WRITE) && tcnt == `T_IDLE && fifo_out_valid;
  wire last_byte = byte_cnt == block_len;
  wire host_wr = !owner && !chip_enable_wait_b && !io_request_strobe_in_b
    && !write_strobe_in_b;
  wire host_rd = !owner && !chip_enable_wait_b && !io_request_strobe_in_b
    && !read_strobe_in_b;
  wire hw_pulse = host_wr && !host_wr_q;
  wire rd_end = host_rd_q && !host_rd;
  assign slot = first_pend(pend);

  // ----------------------------------------
  // data path buffer
  // ----------------------------------------
  dma_byte_fifo #(
    .WIDTH(8),
    .DEPTH(32),
    .AW(5)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_valid(rd_done),
    .in_data(rd_byte),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(wr_done)
  );

  // ----------------------------------------
  // read register selection
  // ----------------------------------------
  always @* begin
    case (read_ptr)
      3'h0: begin
        rr_val = `ZERO8;
        rr_val[`ST_XFER] = xfer_seen;
        rr_val[`ST_READY] = ready_act;
        rr_val[`ST_NOT_END] = !block_end;
      end
      3'h1: rr_val = byte_cnt[7:0];
      3'h2: rr_val = byte_cnt[15:8];
      3'h3: rr_val = cnt_a[7:0];
      3'h4: rr_val = cnt_a[15:8];
      3'h5: rr_val = cnt_b[7:0];
      3'h6: rr_val = cnt_b[15:8];
      default: rr_val = `ZERO8;
    endcase
  end

  // ----------------------------------------
  // programming and counters
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      enabled <= 1'b0;
      op <= 2'h0;
      dir_a2b <= 1'b0;
      start_a <= `ZERO16;
      start_b <= `ZERO16;
      block_len <= `ZERO16;
      cnt_a <= `ZERO16;
      cnt_b <= `ZERO16;
      byte_cnt <= `ZERO16;
      timing_a_base <= `ZERO8;
      timing_b_base <= `ZERO8;
      timing_a_var <= `ZERO8;
      timing_b_var <= `ZERO8;
      var_a <= 1'b0;
      var_b <= 1'b0;
      mode <= `MODE_BYTE;
      rdy_high <= 1'b0;
      wait_en <= 1'b0;
      auto_restart <= 1'b0;
      read_mask <= `RST_READ_MASK;
      read_ptr <= 3'h0;
      pend <= `PEND_NONE;
      xfer_seen <= 1'b0;
      block_end <= 1'b0;
    end else if (hw_pulse) begin
      enabled <= 1'b0;
      if (pend == `PEND_NONE) begin
        if (!data_in[`BASE_HI]) begin
          if (data_in[`GROUP_LO] != 2'h0) begin
            op <= data_in[`GROUP_LO];
            dir_a2b <= data_in[`DIR_BIT];
            pend[`P_LEN_HI:`P_A_LO] <= data_in[`XFER_PTRS];
          end else if (data_in[`DIR_BIT]) begin
            timing_a_base <= data_in;
            pend[`P_TIM_A] <= data_in[`TB_FOLLOW];
          end else begin
            timing_b_base <= data_in;
            pend[`P_TIM_B] <= data_in[`TB_FOLLOW];
          end
        end else begin
          case (data_in[`GROUP_LO])
            2'h0: begin
              pend[`P_MASK] <= data_in[`CB_MASK];
              pend[`P_MATCH] <= data_in[`CB_MATCH];
            end
            2'h1: begin
              mode <= data_in[`MODE_FIELD];
              pend[`P_B_LO] <= data_in[`MB_B_LO];
              pend[`P_B_HI] <= data_in[`MB_B_HI];
              pend[`P_INTCTL] <= data_in[`MB_INTCTL];
            end
            2'h2: begin
              rdy_high <= data_in[`RW_RDY_HIGH];
              wait_en <= data_in[`RW_WAIT];
              auto_restart <= data_in[`RW_RESTART];
            end
            default: begin
              case (data_in)
                `CMD_ENABLE: enabled <= 1'b1;
                `CMD_LOAD: begin
                  if (dir_a2b) begin
                    cnt_a <= start_a;
                  end else begin
                    cnt_b <= start_b;
                  end
                  byte_cnt <= `ZERO16;
                  block_end <= 1'b0;
                end
                `CMD_INIT_READ, `CMD_READ_STATUS: begin
                  read_ptr <= read_mask[0] ? 3'h0 : next_unmasked(read_mask, 3'h0);
                end
                `CMD_READ_MASK: pend[`P_RMASK] <= 1'b1;
                `CMD_RESET: begin
                  var_a <= 1'b0;
                  var_b <= 1'b0;
                  wait_en <= 1'b0;
                  auto_restart <= 1'b0;
                  xfer_seen <= 1'b0;
                end
                default: enabled <= 1'b0;
              endcase
            end
          endcase
        end
      end else begin
        pend[slot] <= 1'b0;
        case (slot)
          `P_A_LO: start_a[7:0] <= data_in;
          `P_A_HI: start_a[15:8] <= data_in;
          `P_LEN_LO: block_len[7:0] <= data_in;
          `P_LEN_HI: block_len[15:8] <= data_in;
          `P_TIM_A: begin
            timing_a_var <= data_in;
            var_a <= 1'b1;
          end
          `P_TIM_B: begin
            timing_b_var <= data_in;
            var_b <= 1'b1;
          end
          `P_B_LO: start_b[7:0] <= data_in;
          `P_B_HI: start_b[15:8] <= data_in;
          `P_INTCTL: begin
            pend[`P_PULSE] <= data_in[`IC_PULSE];
            pend[`P_VECTOR] <= data_in[`IC_VECTOR];
          end
          `P_RMASK: read_mask <= data_in[`RMASK_FIELD];
          // interrupt and search bytes are accepted and dropped
          default: pend[slot] <= 1'b0;
        endcase
      end
    end else begin
      if (rd_end) begin
        read_ptr <= next_unmasked(read_mask, read_ptr);
      end
      if (wr_done) begin
        byte_cnt <= byte_cnt + 16'h0001;
        xfer_seen <= 1'b1;
        cnt_a <= step_addr(cnt_a, timing_a_base);
        cnt_b <= step_addr(cnt_b, timing_b_base);
        if (last_byte) begin
          block_end <= 1'b1;
          if (auto_restart) begin
            byte_cnt <= `ZERO16;
            if (dir_a2b) begin
              cnt_a <= start_a;
            end else begin
              cnt_b <= start_b;
            end
          end else begin
            enabled <= 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // bus master sequencing
  // ----------------------------------------
  always @* begin
    next_state = state;
    next_tcnt = tcnt;
    next_ph = ph;
    case (state)
      S_IDLE: begin
        // request once ready and bus free
        if (enabled && ready_act && bus_request_line_in_b && bus_grant_in_b) begin
          next_state = S_REQ;
        end
      end
      S_REQ: begin
        if (!enabled) begin
          next_state = S_DROP;
        end else if (!bus_grant_in_b) begin
          next_state = S_GRANT;
        end
      end
      S_GRANT: begin
        next_state = bus_grant_in_b ? S_REQ : S_READ;
        next_tcnt = `T_IDLE;
      end
      S_READ, S_WRITE: begin
        if (tcnt == `T_IDLE) begin
          if (cyc_start_rd || cyc_start_wr) begin
            next_tcnt = `T_FIRST;
            next_ph = 1'b0;
          end else if (state == S_READ && mode != `MODE_CONT && !ready_act) begin
            // burst gives the bus back, continuous idles holding it
            next_state = S_DROP;
          end
        end else if (!ph) begin
          next_ph = 1'b1;
        end else if (hold_wait) begin
          // repeat the period while wait is low
          next_ph = 1'b0;
        end else if (at_last) begin
          next_tcnt = `T_IDLE;
          if (state == S_READ) begin
            next_state = S_WRITE;
          end else if ((last_byte && !auto_restart) || mode == `MODE_BYTE) begin
            next_state = S_DROP;
          end else begin
            next_state = S_READ;
          end
        end else begin
          next_tcnt = tcnt + 3'h1;
          next_ph = 1'b0;
        end
      end
      S_DROP: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // strobe view of the coming cycle state
  wire nxt_own = (next_state == S_READ) || (next_state == S_WRITE);
  wire nxt_act = nxt_own && next_tcnt != `T_IDLE && next_state == state;
  wire nxt_tail = next_tcnt == cur_len && next_ph && cur_var;
  wire [15:0] nxt_addr = (next_state == S_WRITE) == dir_a2b ? cnt_b : cnt_a;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_IDLE;
      tcnt <= `T_IDLE;
      ph <= 1'b0;
      rd_byte <= `ZERO8;
      hold_data <= 1'b0;
      host_wr_q <= 1'b0;
      host_rd_q <= 1'b0;
      data_out <= `ZERO8;
      data_oe_b <= 1'b1;
      addr_out <= `ZERO16;
      addr_oe_b <= 1'b1;
      io_request_strobe_out_b <= 1'b1;
      memory_request_strobe_b <= 1'b1;
      read_strobe_out_b <= 1'b1;
      write_strobe_out_b <= 1'b1;
      ctrl_oe_b <= 1'b1;
      bus_request_line_out <= 1'b0;
      bus_request_line_oe_b <= 1'b1;
    end else begin
      state <= next_state;
      tcnt <= next_tcnt;
      ph <= next_ph;
      host_wr_q <= host_wr;
      host_rd_q <= host_rd;
      // open drain request pulled low while wanted
      bus_request_line_oe_b <= !(next_state == S_REQ || next_state == S_GRANT || nxt_own);
      addr_oe_b <= !nxt_own;
      ctrl_oe_b <= !nxt_own;
      addr_out <= nxt_addr;
      // trailing edges half a period early
      io_request_strobe_out_b <= !(nxt_act && cur_io
        && !(nxt_tail && cur_tv[`TV_IO_REQUEST_STROBE_EARLY]));
      memory_request_strobe_b <= !(nxt_act && !cur_io
        && !(nxt_tail && cur_tv[`TV_MEMORY_REQUEST_STROBE_EARLY]));
      read_strobe_out_b <= !(nxt_act && state == S_READ
        && !(nxt_tail && cur_tv[`TV_RD_EARLY]));
      write_strobe_out_b <= !(nxt_act && state == S_WRITE
        && !(nxt_tail && cur_tv[`TV_WR_EARLY]));
      // latch at the falling edge of the last period
      if (state == S_READ && at_last && !ph && tcnt != `T_IDLE) begin
        rd_byte <= data_in;
        data_out <= data_in;
        hold_data <= 1'b1;
      end else if (cyc_start_wr) begin
        data_out <= fifo_out_data;
      end else if (wr_done) begin
        hold_data <= 1'b0;
      end else if (host_rd) begin
        // host read data one clock after select
        data_out <= rr_val;
      end
      data_oe_b <= !((hold_data && !wr_done) || host_rd);
    end
  end
endmodule

// file: verif/dma_bus_partner.sv
`timescale 1ns/1ps
module dma_bus_partner (
  input wire clk_sys,
  input wire slow,
  input wire host_drive,
  input wire [7:0] host_byte,
  input wire [7:0] data_out,
  input wire data_oe_b,
  input wire [15:0] addr_out,
  input wire ctrl_oe_b,
  input wire memory_request_strobe_b,
  input wire read_strobe_out_b,
  input wire write_strobe_out_b,
  input wire bus_request_line_out,
  input wire bus_request_line_oe_b,
  output logic bus_request_line_in_b,
  output logic bus_grant_in_b,
  output logic [7:0] data_in,
  output int writes,
  output logic [15:0] last_addr,
  output logic [7:0] last_data
);
  logic [7:0] float_q = 8'h00;
  logic wr_q = 1'b1;
  int wait_n = 0;
  initial bus_grant_in_b = 1'b1;
  initial writes = 0;
  // pull-up keeps the request line high when nobody pulls
  assign bus_request_line_in_b = bus_request_line_oe_b ? 1'b1 : bus_request_line_out;
  // released bus shows a changing pattern, never the last value
  always @* begin
    if (!data_oe_b) data_in = data_out;
    else if (!ctrl_oe_b && !read_strobe_out_b && !memory_request_strobe_b)
      data_in = addr_out[7:0] ^ addr_out[15:8] ^ 8'h5a;
    else if (host_drive) data_in = host_byte;
    else data_in = float_q;
  end
  always @(posedge clk_sys) begin
    float_q <= float_q + 8'h3b;
    wr_q <= write_strobe_out_b;
    if (bus_request_line_in_b) begin
      wait_n <= 0;
      bus_grant_in_b <= 1'b1;
    end else begin
      wait_n <= wait_n + 1;
      if (wait_n >= (slow ? 5 : 1)) bus_grant_in_b <= 1'b0;
    end
    if (!write_strobe_out_b) begin
      last_addr <= addr_out;
      last_data <= data_out;
    end
    if (write_strobe_out_b && !wr_q) writes <= writes + 1;
  end
endmodule

// file: verif/dma_checker.sv
`timescale 1ns/1ps
module dma_checker (
  input wire clk_sys, rst_b, data_oe_b, chip_enable_wait_b, io_request_strobe_in_b,
  input wire read_strobe_in_b, write_strobe_in_b, addr_oe_b, ctrl_oe_b,
  input wire io_request_strobe_out_b, memory_request_strobe_b, read_strobe_out_b,
  input wire write_strobe_out_b, bus_request_line_out, bus_request_line_oe_b,
  input wire bus_request_line_in_b, bus_grant_in_b,
  input wire [7:0] data_in
);
  wire host_sel = !chip_enable_wait_b && !io_request_strobe_in_b;
  wire host_rd = host_sel && !read_strobe_in_b;
  wire host_wr = host_sel && !write_strobe_in_b;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  a_request_open_drain: assert property (bus_request_line_out == 1'b0)
    else $error("request line driven high");
  a_request_when_free: assert property ($fell(bus_request_line_oe_b)
    |-> $past(bus_request_line_in_b)) else $error("request while bus busy");
  a_grant_two_edges: assert property ($fell(addr_oe_b)
    |-> !$past(bus_grant_in_b, 1) && !$past(bus_grant_in_b, 2))
    else $error("bus taken early");
  a_write_disables: assert property ($rose(host_wr) && addr_oe_b && data_in != 8'h87
    |-> ##2 bus_request_line_oe_b [*3]) else $error("request after write");
  a_read_answer: assert property ($rose(host_rd) && addr_oe_b |=> !data_oe_b)
    else $error("host read not answered");
  a_data_held_write: assert property (!write_strobe_out_b
    |-> !data_oe_b && !ctrl_oe_b) else $error("write without data");
  a_mem_read_len: assert property ($fell(read_strobe_out_b)
    && !memory_request_strobe_b |-> !read_strobe_out_b [*4]) else $error("memory read short");
  a_io_write_len: assert property ($fell(write_strobe_out_b)
    && !io_request_strobe_out_b |-> !write_strobe_out_b [*5]) else $error("io write short");
  c_grant: cover property ($fell(addr_oe_b));
  c_host_read: cover property ($rose(host_rd));
  c_io_write: cover property ($fell(write_strobe_out_b) && !io_request_strobe_out_b);
endmodule
bind single_channel_dma_controller dma_checker chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .data_oe_b(data_oe_b), .chip_enable_wait_b(chip_enable_wait_b),
  .io_request_strobe_in_b(io_request_strobe_in_b), .read_strobe_in_b(read_strobe_in_b),
  .write_strobe_in_b(write_strobe_in_b), .addr_oe_b(addr_oe_b), .ctrl_oe_b(ctrl_oe_b),
  .io_request_strobe_out_b(io_request_strobe_out_b), .data_in(data_in),
  .memory_request_strobe_b(memory_request_strobe_b), .read_strobe_out_b(read_strobe_out_b),
  .write_strobe_out_b(write_strobe_out_b), .bus_request_line_out(bus_request_line_out),
  .bus_request_line_oe_b(bus_request_line_oe_b), .bus_grant_in_b(bus_grant_in_b),
  .bus_request_line_in_b(bus_request_line_in_b));

// file: verif/test_single_channel_dma_controller.sv
`timescale 1ns/1ps
module test_single_channel_dma_controller;
  logic clk_sys = 1'b0, rst_b = 1'b0, chip_enable_wait_b = 1'b1, io_request_strobe_in_b = 1'b1;
  logic read_strobe_in_b = 1'b1, write_strobe_in_b = 1'b1, ready_in = 1'b0, slow = 1'b0;
  logic host_drive = 1'b0, data_oe_b, addr_oe_b, io_request_strobe_out_b, ctrl_oe_b;
  logic memory_request_strobe_b, read_strobe_out_b, write_strobe_out_b, bus_grant_in_b;
  logic bus_request_line_out, bus_request_line_oe_b, bus_request_line_in_b;
  logic [7:0] host_byte = 8'h00, data_in, data_out, q, last_data, blo, len;
  logic [15:0] addr_out, last_addr, a_start;
  logic [31:0] seed = 32'h628e_8387;
  int num_errors = 0, tests_run = 0, cycles = 0, writes, w0;
  single_channel_dma_controller dut (.*);
  dma_bus_partner partner (.*);
  always #2 clk_sys = ~clk_sys;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  function automatic logic [7:0] exp_mem(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // strobes held three edges, then dropped for a clock between bytes
  task automatic host(input logic wr, input logic [7:0] b);
    host_byte = b;
    host_drive = wr;
    chip_enable_wait_b = 1'b0;
    io_request_strobe_in_b = 1'b0;
    write_strobe_in_b = !wr;
    read_strobe_in_b = wr;
    step(3);
    q = data_in;
    chip_enable_wait_b = 1'b1;
    io_request_strobe_in_b = 1'b1;
    write_strobe_in_b = 1'b1;
    read_strobe_in_b = 1'b1;
    host_drive = 1'b0;
    step(1);
  endtask
  task automatic prog(input logic [7:0] b[$]);
    foreach (b[i]) host(1'b1, b[i]);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    step(3);
    rst_b = 1'b1;
    // ready is active low after reset, so only the disabled state holds requests back
    step(20);
    chk("request after reset", 16'h0001, {15'h0, bus_request_line_oe_b});
    $display("test reset_idle done");
    for (int i = 0; i < 3; i++) begin
      a_start = {lfsr(), lfsr()};
      prog('{8'h7d, a_start[7:0], a_start[15:8], 8'h00, 8'h00, 8'hcf, 8'hbb, 8'h1e, 8'ha7});
      host(1'b0, 8'h00);
      chk("count low", 16'h0000, {8'h00, q});
      host(1'b0, 8'h00);
      chk("count high", 16'h0000, {8'h00, q});
      host(1'b0, 8'h00);
      chk("port a low", {8'h00, a_start[7:0]}, {8'h00, q});
      host(1'b0, 8'h00);
      chk("port a high", {8'h00, a_start[15:8]}, {8'h00, q});
    end
    $display("test read_back done");
    for (int i = 0; i < 3; i++) begin
      slow = i[0];
      a_start = {lfsr(), lfsr()};
      blo = lfsr();
      len = lfsr() & 8'h03;
      w0 = writes;
      ready_in = 1'b0;
      prog('{8'h79, a_start[7:0], a_start[15:8], len, 8'h00, 8'h14, 8'h28, 8'hc5, blo,
             8'h8a | (i == 2 ? 8'h10 : 8'h00), 8'hcf, 8'h05, 8'hcf});
      ready_in = 1'b1;
      prog('{8'h87});
      // random wait level, last pass only
      for (int k = 0; k < 2000 && writes - w0 < int'(len) + 1; k++) begin
        q = lfsr();
        chip_enable_wait_b = !(i == 2 && q[0]);
        step(1);
      end
      chip_enable_wait_b = 1'b1;
      step(40);
      chk("bytes moved", {8'h00, len} + 16'h0001, 16'(writes - w0));
      chk("dest address", {8'h00, blo}, {8'h00, last_addr[7:0]});
      chk("last data", {8'h00, exp_mem(a_start + {8'h00, len})}, {8'h00, last_data});
      chk("bus released", 16'h0001, {15'h0, bus_request_line_oe_b});
      $display("test transfer %0d done", i);
    end
    test_done();
  end
endmodule
